// >>> design/aas_pkg.sv
// Constants, register indices and state codes for the ATAPI sequencer.
// Assumes an APB master with 32-bit data; byte address = index * 4.
// What this block does
// RULE1: Firmware loads remaining block count with blocks minus one; zero means single block.
// RULE2: Writing one to block-count bump adds one to the remaining count.
// RULE3: Bump-pending flag reads high from request until the increment lands.
// RULE4: Both per-block enables set: hold micro interrupt low from each nonfinal block end until the per-block flag clears.
// RULE5: Per-block flag enable set: raise per-block flag at each nonfinal block end.
// RULE6: Debug control register clears on chip, host and firmware reset.
// RULE7: Every trigger bit clears itself when its operation has finished.
// RULE8: Soft-reset-clear trigger clears the host SRST bit.
// RULE9: Seek-done trigger: with wrap BSY, DSC, unBSY; without wrap only DSC.
// RULE10: Signature trigger loads fixed task values, status cleared except two bits.
// RULE11: Signature trigger leaves drive/head register untouched.
// RULE12: Packet-queue clear trigger empties the command packet FIFO.
// RULE13: PIO transfer start: BSY, enable, select and reason by direction, count load.
// RULE14: PIO start then FIFO ready: DRQ, clear BSY, host interrupt in order.
// RULE15: DMA transfer start does the same setup without the count load or the DRQ tail.
// RULE16: Firmware writes multi-block byte count itself unless assist is enabled.
// RULE17: Request trigger in PIO and DMA alike: DRQ, clear BSY, host interrupt.
// RULE18: Status-done: copy pending bits, reason 03h, unBSY, irq, rearm, clear auto-status.
// RULE19: A0h with auto-packet and drive selected runs packet sequence under BSY.
// RULE20: Sixth packet word sets packet-full, drives transfer-end low, optional pin irq.
// RULE21: Any acknowledge write clears packet-seen, transfer-end and its interrupt.
// RULE22: Auto request-clear: end of RAM read or packet write clears DRQ, sets BSY.
// RULE23: Auto-status: end of such transfer runs status completion, BSY/DRQ first when auto request-clear is set.
// RULE24: CRC gate blocks auto completion on CRC error; gate self-clears when used.
// RULE25: Nonfinal block end reloads, bumps RAM block, decrements; final ends transfer.
// RULE26: Packet irq enable with auto-packet raises host irq after A0h command.
// RULE27: Sequence steps land on successive clocks; BSY clears last, and only the host interrupt step follows it.
package aas_pkg;
  // Register indices
  localparam logic [7:0] IDX_XFER = 8'h01;
  localparam logic [7:0] IDX_ACK = 8'h07;
  localparam logic [7:0] IDX_CNT = 8'h12;
  localparam logic [7:0] IDX_DBG = 8'h13;
  localparam logic [7:0] IDX_TRIG = 8'h17;
  localparam logic [7:0] IDX_CTRL = 8'h18;
  localparam logic [7:0] IDX_FLAGS = 8'h30;
  localparam logic [7:0] IDX_ERR = 8'h31;
  localparam logic [7:0] IDX_REASON = 8'h32;
  localparam logic [7:0] IDX_SECTOR = 8'h33;
  localparam logic [7:0] IDX_CLO = 8'h34;
  localparam logic [7:0] IDX_CHI = 8'h35;
  localparam logic [7:0] IDX_STATUS = 8'h37;
  localparam logic [7:0] IDX_PEND = 8'h3e;
  // Trigger bits
  localparam int T_CSR = 6, T_DSC = 5, T_SIG = 4, T_PQC = 3;
  localparam int T_ADT = 2, T_DRQ = 1, T_SCT = 0;
  localparam logic [7:0] SEQ_TRIG_MASK = 8'h37;
  // Control bits
  localparam int C_PACKET_CMD_SEEN = 7, C_ADC = 6, C_ASC = 5, C_AUTO = 4;
  localparam int C_STWC = 3, C_CRC = 2, C_WRAP = 1, C_A0I = 0;
  // Status, transfer and flag bits
  localparam int S_BSY = 7, S_DRDY = 6, S_DSC = 4, S_DRQ = 3;
  localparam int S_CORR = 2, S_CHK = 0;
  localparam logic [7:0] SIG_KEEP_MASK = 8'h90;
  localparam int X_END_IEN = 6, X_EN = 2;
  localparam int F_SEEN = 0, F_FULL = 1, F_CRC = 3, F_BLK = 4, F_CMD = 6;
  localparam int D_PIN = 2, D_FLAG = 1, D_BUMP = 0;
  // Fixed task values
  localparam logic [7:0] SIG_ERROR = 8'h01;
  localparam logic [7:0] SIG_REASON = 8'h01;
  localparam logic [7:0] SIG_SECTOR = 8'h01;
  localparam logic [7:0] SIG_CLO = 8'h14;
  localparam logic [7:0] SIG_CHI = 8'heb;
  localparam logic [7:0] REASON_IN = 8'h02;
  localparam logic [7:0] REASON_OUT = 8'h00;
  localparam logic [7:0] REASON_DONE = 8'h03;
  localparam logic [7:0] PKT_ERROR = 8'h00;
  localparam logic [7:0] PKT_REASON = 8'h01;
  localparam logic [7:0] OPC_PACKET = 8'ha0;
  localparam logic [2:0] PKT_LAST_WORD = 3'd5;
  // Reset values
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [4:0] RST_COUNT = 5'h00;
  typedef enum logic [3:0] {
    ST_IDLE = 4'h0, ST_XF_B = 4'h1, ST_XF_L = 4'h3, ST_XF_W = 4'h2,
    ST_DRQ = 4'h6, ST_UNBSY = 4'h7, ST_IRQ = 4'h5, ST_SC_B = 4'h4,
    ST_SC_S = 4'hc, ST_PK_B = 4'hd, ST_PK_L = 4'hf, ST_DSC_B = 4'he,
    ST_DSC_S = 4'ha, ST_SIG = 4'hb, ST_DSC_O = 4'h9
  } aas_state_t;
endpackage

// >>> design/aas_sequencer.sv
// Auto-sequencer for the ATAPI task file, with packet and block counters.
// Assumes host-side strobes are one-cycle pulses synchronous to pclk.
//
// Register access over APB is this design's own decision.
`timescale 1ns/1ns
module aas_sequencer (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic host_reset,
  input wire logic fw_reset,
  input wire logic host_cmd_wr,
  input wire logic [7:0] host_cmd_data,
  input wire logic drive_selected,
  input wire logic host_srst_set,
  input wire logic host_status_read,
  input wire logic host_pkt_word_wr,
  input wire logic host_ram_read_done,
  input wire logic host_pkt_write_done,
  input wire logic block_end,
  input wire logic pio_mode,
  input wire logic direction_out,
  input wire logic [15:0] block_word_count,
  input wire logic fifo_ready_n,
  input wire logic burst_crc_bad,
  output logic [7:0] task_error,
  output logic [7:0] task_reason,
  output logic [7:0] task_sector_no,
  output logic [7:0] task_count_low,
  output logic [7:0] task_count_high,
  output logic [7:0] task_status,
  output logic srst,
  output logic cmd_vs_payload_sel,
  output logic xfer_enable,
  output logic host_irq,
  output logic pkt_fifo_clear,
  output logic block_reload,
  output logic micro_irq_n
);
  import aas_pkg::*;

  aas_state_t st_q, st_d;
  logic [7:0] trig_q, act_q, act_d, ctrl_q, pend_q, xfer_q;
  logic [7:0] err_q, reason_q, sector_q, clo_q, chi_q, status_q;
  logic [4:0] cnt_q;
  logic [2:0] dbg_q, words_q;
  logic [31:0] prdata_q;
  logic bump_pend_q, valid_n_q, blk_flag_q, seen_q, full_q, cmd_q;
  logic end_n_q, srst_q, cod_q, host_irq_q, pclr_q, reload_q;
  logic pkt_req_q, sc_req_q, sc_tail_q, irq_tail_q;

  // Bus decode; one idle-free access phase, pready always high
  wire [7:0] idx = paddr[9:2];
  wire hit = (idx == IDX_XFER) || (idx == IDX_ACK) || (idx == IDX_CNT) ||
             (idx == IDX_DBG) || (idx == IDX_TRIG) || (idx == IDX_CTRL) ||
             (idx == IDX_FLAGS) || (idx == IDX_ERR) ||
             (idx == IDX_REASON) || (idx == IDX_SECTOR) ||
             (idx == IDX_CLO) || (idx == IDX_CHI) ||
             (idx == IDX_STATUS) || (idx == IDX_PEND);
  wire wr = psel && penable && pwrite && hit && (paddr[11:10] == 2'b00);
  wire wr_cnt = wr && (idx == IDX_CNT);
  wire wr_dbg = wr && (idx == IDX_DBG);
  wire wr_trig = wr && (idx == IDX_TRIG);
  wire wr_ctrl = wr && (idx == IDX_CTRL);
  wire wr_xfer = wr && (idx == IDX_XFER);
  wire wr_ack = wr && (idx == IDX_ACK);
  wire wr_flags = wr && (idx == IDX_FLAGS);
  wire wr_pend = wr && (idx == IDX_PEND);
  wire soft_clr = host_reset || fw_reset;
  assign pready = 1'b1;
  assign pslverr = psel && penable && !(hit && (paddr[11:10] == 2'b00));

  // Read mux, sampled in the setup phase so prdata comes from a flop
  wire [7:0] rd_byte =
    (idx == IDX_CNT) ? {valid_n_q, bump_pend_q, 1'b0, cnt_q} :
    (idx == IDX_DBG) ? {5'd0, dbg_q[2:1], bump_pend_q} :
    (idx == IDX_TRIG) ? trig_q :
    (idx == IDX_CTRL) ? ctrl_q :
    (idx == IDX_XFER) ? {1'b0, end_n_q, xfer_q[5:3], xfer_q[X_EN], fifo_ready_n,
                         1'b0} :
    (idx == IDX_FLAGS) ? {1'b0, cmd_q, 1'b0, blk_flag_q, burst_crc_bad, 1'b0,
                          full_q, seen_q} :
    (idx == IDX_ERR) ? err_q :
    (idx == IDX_REASON) ? reason_q :
    (idx == IDX_SECTOR) ? sector_q :
    (idx == IDX_CLO) ? clo_q :
    (idx == IDX_CHI) ? chi_q :
    (idx == IDX_STATUS) ? status_q :
    (idx == IDX_PEND) ? pend_q : RST_BYTE;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= 32'h0000_0000;
    end else if (psel && !penable) begin
      prdata_q <= {24'h00_0000, rd_byte};
    end
  end
  assign prdata = prdata_q;

  // Block counter: bump and per-block decrement share one adder; a load wins over both
  wire dec = block_end && (cnt_q != 5'd0);
  wire final_end = block_end && (cnt_q == 5'd0);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q <= RST_COUNT;
      bump_pend_q <= 1'b0;
      dbg_q <= 3'd0;
      valid_n_q <= 1'b0;
      blk_flag_q <= 1'b0;
      reload_q <= 1'b0;
    end else if (soft_clr) begin
      cnt_q <= RST_COUNT;  // see RULE6
      bump_pend_q <= 1'b0;
      dbg_q <= 3'd0;  // see RULE6
      valid_n_q <= 1'b0;
      blk_flag_q <= 1'b0;
      reload_q <= 1'b0;
    end else begin
      if (wr_cnt) begin
        cnt_q <= pwdata[4:0];  // see RULE1
      end else begin
        cnt_q <= cnt_q + {4'd0, bump_pend_q} - {4'd0, dec};  // see RULE2 RULE25
      end
      // Request sets the flag even in its clearing cycle
      bump_pend_q <= wr_dbg ? pwdata[D_BUMP] : 1'b0;  // see RULE3
      if (wr_dbg) begin
        dbg_q <= {pwdata[D_PIN], pwdata[D_FLAG], 1'b0};
      end
      valid_n_q <= wr_cnt || bump_pend_q || dec;
      blk_flag_q <= (dec && dbg_q[D_FLAG]) ||
                    (blk_flag_q && !(wr_flags && pwdata[F_BLK]));  // see RULE5
      reload_q <= dec;  // see RULE25
    end
  end
  assign block_reload = reload_q;
  // Per-block pin needs both enables; transfer-end pin needs its enable
  assign micro_irq_n = !((blk_flag_q && dbg_q[D_PIN] && dbg_q[D_FLAG]) ||
                         (!end_n_q && xfer_q[X_END_IEN]));  // see RULE4 RULE20

  // Host transfer ends and the CRC gate decide on automatic completion
  wire xfer_done = host_ram_read_done || host_pkt_write_done;
  wire crc_block = ctrl_q[C_CRC] && burst_crc_bad;
  wire pkt_cmd = host_cmd_wr && (host_cmd_data == OPC_PACKET) &&
                 drive_selected && ctrl_q[C_PACKET_CMD_SEEN];
  wire idle = (st_q == ST_IDLE);
  wire go_pkt = idle && pkt_req_q;
  wire go_asc = idle && !pkt_req_q && sc_req_q;
  wire go_any = idle && (pkt_req_q || sc_req_q || (trig_q[5:0] != 6'd0));
  wire finish = !idle && (st_d == ST_IDLE);

  // Dispatch: host packet first, then auto status, then triggers
  always_comb begin
    st_d = st_q;
    act_d = act_q;
    case (st_q)
      ST_IDLE: begin
        act_d = 8'h00;
        if (pkt_req_q) begin
          st_d = ST_PK_B;
        end else if (sc_req_q) begin
          st_d = ST_SC_B;
        end else if (trig_q[T_SIG]) begin
          st_d = ST_SIG;
          act_d = 8'h10;
        end else if (trig_q[T_DSC]) begin
          st_d = ctrl_q[C_WRAP] ? ST_DSC_B : ST_DSC_O;
          act_d = 8'h20;
        end else if (trig_q[T_ADT]) begin
          st_d = ST_XF_B;
          act_d = 8'h04;
        end else if (trig_q[T_DRQ]) begin
          st_d = ST_DRQ;
          act_d = 8'h02;
        end else if (trig_q[T_SCT]) begin
          st_d = ST_SC_S;
          act_d = 8'h01;
        end
      end
      ST_SIG, ST_DSC_O: st_d = ST_IDLE;
      ST_DSC_B: st_d = ST_DSC_S;
      ST_DSC_S: st_d = ST_UNBSY;
      ST_XF_B: st_d = ST_XF_L;
      ST_XF_L: st_d = pio_mode ? ST_XF_W : ST_IDLE;  // see RULE15
      ST_XF_W: st_d = fifo_ready_n ? ST_XF_W : ST_DRQ;  // see RULE14
      ST_DRQ: st_d = ST_UNBSY;
      ST_UNBSY: st_d = irq_tail_q ? ST_IRQ : ST_IDLE;
      ST_IRQ: st_d = ST_IDLE;
      ST_SC_B: st_d = ST_SC_S;
      ST_SC_S: st_d = ST_UNBSY;
      ST_PK_B: st_d = ST_PK_L;
      ST_PK_L: st_d = ST_UNBSY;
      default: st_d = ST_IDLE;
    endcase
  end

  // Trigger bits stay set until their own sequence returns to idle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q <= ST_IDLE;
      act_q <= 8'h00;
      trig_q <= 8'h00;
      pkt_req_q <= 1'b0;
      sc_req_q <= 1'b0;
    end else begin
      st_q <= st_d;
      act_q <= act_d;
      trig_q <= (trig_q & ~(finish ? act_q : 8'h00)) |
                (wr_trig ? (pwdata[7:0] & SEQ_TRIG_MASK) : 8'h00);  // see RULE7
      pkt_req_q <= pkt_cmd || (pkt_req_q && !go_pkt);
      sc_req_q <= (xfer_done && ctrl_q[C_ASC] && !crc_block) ||
                  (sc_req_q && !go_asc);  // see RULE23 RULE24
    end
  end

  // Sequence ends that raise the host interrupt or re-arm
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sc_tail_q <= 1'b0;
      irq_tail_q <= 1'b0;
    end else if (go_any) begin
      sc_tail_q <= (st_d == ST_SC_B) || (st_d == ST_SC_S);
      irq_tail_q <= (st_d != ST_PK_B) && (st_d != ST_DSC_B);
    end
  end

  // Control register: hardware updates override the bus write
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= RST_BYTE;
    end else begin
      ctrl_q <= wr_ctrl ? pwdata[7:0] : ctrl_q;
      if (go_asc || (wr_trig && pwdata[T_SCT])) begin
        ctrl_q[C_CRC] <= 1'b0;  // see RULE24
      end
      if (st_q == ST_PK_L) begin
        ctrl_q[C_PACKET_CMD_SEEN] <= 1'b0;  // see RULE19
      end
      if ((st_q == ST_IRQ) && sc_tail_q) begin
        ctrl_q[C_ASC] <= 1'b0;  // see RULE18
        if (ctrl_q[C_AUTO]) begin
          ctrl_q[C_PACKET_CMD_SEEN] <= 1'b1;
        end
      end
    end
  end

  // Task file: one step of each sequence per clock, BSY cleared last
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      err_q <= RST_BYTE;
      reason_q <= RST_BYTE;
      sector_q <= RST_BYTE;
      clo_q <= RST_BYTE;
      chi_q <= RST_BYTE;
      status_q <= RST_BYTE;
      cod_q <= 1'b0;
    end else begin
      if (xfer_done && ctrl_q[C_ADC]) begin
        status_q[S_DRQ] <= 1'b0;  // see RULE22
        status_q[S_BSY] <= 1'b1;
      end
      case (st_q)
        ST_SIG: begin
          err_q <= SIG_ERROR;  // see RULE10
          reason_q <= SIG_REASON;
          sector_q <= SIG_SECTOR;
          clo_q <= SIG_CLO;
          chi_q <= SIG_CHI;
          status_q <= status_q & SIG_KEEP_MASK;  // see RULE11
        end
        ST_DSC_B, ST_XF_B, ST_PK_B: status_q[S_BSY] <= 1'b1;  // see RULE27
        ST_DSC_S, ST_DSC_O: status_q[S_DSC] <= 1'b1;  // see RULE9
        ST_XF_L: begin
          cod_q <= direction_out;  // see RULE13
          reason_q <= direction_out ? REASON_OUT : REASON_IN;
          if (pio_mode && ctrl_q[C_STWC]) begin
            {chi_q, clo_q} <= 16'((block_word_count + 16'd1) << 1);
          end
        end
        ST_DRQ: status_q[S_DRQ] <= 1'b1;  // see RULE17
        ST_UNBSY: status_q[S_BSY] <= 1'b0;
        ST_SC_B: begin
          if (ctrl_q[C_ADC]) begin
            status_q[S_BSY] <= 1'b1;  // see RULE23
            status_q[S_DRQ] <= 1'b0;
          end
        end
        ST_SC_S: begin
          status_q[S_CHK] <= pend_q[S_CHK];  // see RULE18
          status_q[S_CORR] <= pend_q[S_CORR];
          status_q[S_DRDY] <= pend_q[S_DRDY];
          reason_q <= REASON_DONE;
        end
        ST_PK_L: begin
          err_q <= PKT_ERROR;  // see RULE19
          reason_q <= PKT_REASON;
          cod_q <= 1'b1;
          status_q[S_CHK] <= 1'b0;
          status_q[S_CORR] <= 1'b0;
          status_q[S_DRQ] <= 1'b1;
          status_q[S_DRDY] <= 1'b1;
        end
        default: ;
      endcase
    end
  end

  // Firmware-side registers and host-facing flags
  wire pkt_word_last = host_pkt_word_wr && (words_q == PKT_LAST_WORD);
  wire irq_set = (st_q == ST_IRQ) ||
                 ((st_q == ST_PK_L) && ctrl_q[C_A0I]);  // see RULE26
  wire pkt_clear = (wr_trig && pwdata[T_PQC]) || (st_q == ST_PK_B);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pend_q <= RST_BYTE;
      xfer_q <= RST_BYTE;
      words_q <= 3'd0;
      seen_q <= 1'b0;
      full_q <= 1'b0;
      cmd_q <= 1'b0;
      end_n_q <= 1'b1;
      srst_q <= 1'b0;
      host_irq_q <= 1'b0;
      pclr_q <= 1'b0;
    end else begin
      pend_q <= wr_pend ? pwdata[7:0] : pend_q;
      if (wr_xfer) begin
        xfer_q <= pwdata[7:0];
      end else if ((st_q == ST_XF_B) || (st_q == ST_PK_B)) begin
        xfer_q[X_EN] <= 1'b1;  // see RULE13 RULE15
      end
      pclr_q <= pkt_clear;  // see RULE12
      if (pkt_clear) begin
        words_q <= 3'd0;
      end else if (host_pkt_word_wr && !pkt_word_last) begin
        words_q <= words_q + 3'd1;
      end
      seen_q <= (st_q == ST_PK_B) || (seen_q && !wr_ack);  // see RULE21
      full_q <= pkt_word_last || (full_q && !pkt_clear);  // see RULE20
      end_n_q <= !(pkt_word_last || final_end) && (!end_n_q ? wr_ack : 1'b1);
      // Plain commands flag firmware; auto-packet keeps this flag quiet
      cmd_q <= (host_cmd_wr && drive_selected && !pkt_cmd) ||
               (cmd_q && !(wr_flags && pwdata[F_CMD]));  // see RULE19
      srst_q <= host_srst_set || (srst_q && !(wr_trig && pwdata[T_CSR]));
      host_irq_q <= irq_set || (host_irq_q && !host_status_read);
    end
  end

  assign task_error = err_q;
  assign task_reason = reason_q;
  assign task_sector_no = sector_q;
  assign task_count_low = clo_q;
  assign task_count_high = chi_q;
  assign task_status = status_q;
  assign srst = srst_q;  // see RULE8
  assign cmd_vs_payload_sel = cod_q;
  assign xfer_enable = xfer_q[X_EN];
  assign host_irq = host_irq_q;
  assign pkt_fifo_clear = pclr_q;

  // Checks on the sequencer's own outputs
  sequence seq_dsc_wrap;
    status_q[S_BSY] ##1 (status_q[S_BSY] && status_q[S_DSC]) ##1
    !status_q[S_BSY];
  endsequence
  sequence seq_pio_tail;
    status_q[S_DRQ] && status_q[S_BSY] ##1 !status_q[S_BSY] ##1 host_irq_q;
  endsequence

  AST_BUMP_PENDING: assert property (@(posedge pclk) disable iff (!presetn) // see RULE3
    (wr_dbg && pwdata[D_BUMP] && !soft_clr) |=> bump_pend_q ##1 !bump_pend_q)
    else $error("bump pending flag timing wrong");
  AST_BLOCK_PIN: assert property (@(posedge pclk) disable iff (!presetn) // see RULE4
    (dec && dbg_q[D_PIN] && dbg_q[D_FLAG] && !soft_clr) |=> !micro_irq_n)
    else $error("per-block pin interrupt missing");
  AST_TRIG_SELF_CLEAR: assert property (@(posedge pclk) disable iff (!presetn) // see RULE7
    (finish && !wr_trig) |=> ((trig_q & $past(act_q)) == 8'h00))
    else $error("trigger bit did not clear after its sequence");
  AST_DSC_WRAP: assert property (@(posedge pclk) disable iff (!presetn) // see RULE9
    (st_q == ST_DSC_B) |=> seq_dsc_wrap)
    else $error("seek-done wrap out of order");
  AST_SIGNATURE: assert property (@(posedge pclk) disable iff (!presetn) // see RULE10
    (st_q == ST_SIG) |=> (err_q == SIG_ERROR) && (clo_q == SIG_CLO) &&
      (chi_q == SIG_CHI) && ((status_q & ~SIG_KEEP_MASK) == 8'h00))
    else $error("signature values wrong");
  AST_PIO_TAIL: assert property (@(posedge pclk) disable iff (!presetn) // see RULE14
    ((st_q == ST_XF_W) && !fifo_ready_n) |=> ##1 seq_pio_tail)
    else $error("PIO request tail out of order");
  AST_STATUS_DONE: assert property (@(posedge pclk) disable iff (!presetn) // see RULE18
    (st_q == ST_SC_S) |=> (reason_q == REASON_DONE) && status_q[S_BSY]
      ##1 !status_q[S_BSY] ##1 host_irq_q)
    else $error("status completion out of order");
  AST_PACKET_FULL: assert property (@(posedge pclk) disable iff (!presetn) // see RULE20
    (pkt_word_last && !pkt_clear) |=> full_q && !end_n_q)
    else $error("sixth packet word not flagged");
  AST_ACK_CLEARS: assert property (@(posedge pclk) disable iff (!presetn) // see RULE21
    (wr_ack && !pkt_word_last && !final_end && (st_q != ST_PK_B)) |=>
      end_n_q && !seen_q)
    else $error("acknowledge did not release transfer end");
  AST_CRC_GATE: assert property (@(posedge pclk) disable iff (!presetn) // see RULE24
    (xfer_done && crc_block && !sc_req_q) |=> !sc_req_q)
    else $error("completion ran despite CRC error");
endmodule

// >>> tb/aas_host_model.sv
// Host-side partner: data FIFO fill delay and host status reads.
// Assumes one clock shared with the sequencer under test.
`timescale 1ns/1ns
module aas_host_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic xfer_enable,
  input wire logic host_irq,
  output logic fifo_ready_n,
  output logic host_status_read
);
  logic [3:0] fill_q;
  // FIFO turns ready only after some fill cycles, so BSY shows first
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fill_q <= 4'h0;
      fifo_ready_n <= 1'b1;
      host_status_read <= 1'b0;
    end else begin
      fill_q <= xfer_enable ? fill_q + {3'h0, ~&fill_q} : 4'h0;
      fifo_ready_n <= !(xfer_enable && fill_q > 4'h5);
      // Host reads status a cycle after the interrupt, which clears it
      host_status_read <= host_irq && !host_status_read;
    end
  end
endmodule

// >>> tb/aas_sequencer_tb.sv
// Bench for the ATAPI sequencer: APB tasks and directed sequences.
// Assumes the host model answers the FIFO and status-read side.
`timescale 1ns/1ns
module aas_sequencer_tb;
  import aas_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic host_reset, fw_reset, host_cmd_wr, drive_selected, host_srst_set;
  logic host_status_read, host_pkt_word_wr, host_ram_read_done;
  logic host_pkt_write_done, block_end, pio_mode, direction_out;
  logic fifo_ready_n, burst_crc_bad, srst, cmd_vs_payload_sel, xfer_enable;
  logic host_irq, pkt_fifo_clear, block_reload, micro_irq_n;
  logic [7:0] host_cmd_data, task_error, task_reason, task_sector_no, rd;
  logic [7:0] task_count_low, task_count_high, task_status;
  logic [15:0] block_word_count;
  logic [7:0] stb;
  int failures, checks, cyc, reloads, clears;
  // Host strobes share one pulse vector; unused host inputs held idle
  assign {host_cmd_wr, fw_reset, block_end, host_pkt_write_done} = stb[4:1];
  assign host_srst_set = stb[0];
  assign {host_reset, host_pkt_word_wr, host_ram_read_done} = stb[7:5];
  aas_sequencer dut_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .host_reset, .fw_reset,
    .host_cmd_wr, .host_cmd_data, .drive_selected, .host_srst_set,
    .host_status_read, .host_pkt_word_wr, .host_ram_read_done,
    .host_pkt_write_done, .block_end, .pio_mode, .direction_out,
    .block_word_count, .fifo_ready_n, .burst_crc_bad, .task_error,
    .task_reason, .task_sector_no, .task_count_low, .task_count_high,
    .task_status, .srst, .cmd_vs_payload_sel, .xfer_enable, .host_irq,
    .pkt_fifo_clear, .block_reload, .micro_irq_n);
  aas_host_model host_u (.pclk, .presetn, .xfer_enable, .host_irq,
    .fifo_ready_n, .host_status_read);
  // Clock and hang guard
  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end
  // Pulse counters read the value before this edge's update
  always @(posedge pclk) begin
    cyc++;
    if (block_reload === 1'b1) reloads++;
    if (pkt_fifo_clear === 1'b1) clears++;
    if (cyc == 5000) begin
      failures++;
      end_of_test();
    end
  end
  task automatic end_of_test();
    if (failures == 0 && checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    checks++;
    if (got !== exp) begin
      failures++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // One APB transfer, held until pready is sampled high
  task automatic apb(input logic w, input logic [7:0] idx,
    input logic [7:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {2'b00, idx, 2'b00};
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata[7:0];
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic rdc(input logic [7:0] idx, m, e);
    apb(1'b0, idx, 8'h00);
    chk({16'h0, rd & m}, {16'h0, e});
  endtask
  task automatic strobe(input int k);
    stb <= 8'(1 << k);
    @(posedge pclk);
    stb <= 8'h00;
    @(posedge pclk);
  endtask
  task automatic wait_irq();
    int n;
    n = 0;
    while (host_irq !== 1'b1 && n < 60) begin
      @(posedge pclk);
      n++;
    end
    chk(24'(n < 60), 24'h1);
  endtask
  // Directed sequences, each checked as it completes
  initial begin
    {psel, penable, pwrite, pio_mode, direction_out, drive_selected} = '0;
    burst_crc_bad = 1'b0;
    {paddr, pwdata, host_cmd_data, block_word_count, stb} = '0;
    presetn = 1'b0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rdc(IDX_DBG, 8'hff, 8'h00);
    rdc(IDX_CNT, 8'h5f, 8'h00);
    apb(1'b1, IDX_TRIG, 8'h10);
    repeat (6) @(posedge pclk);
    chk({task_error, task_reason, task_sector_no}, 24'h010101);
    chk({task_count_high, task_count_low, task_status & 8'h6f},
      24'heb1400);
    rdc(IDX_TRIG, 8'h37, 8'h00);
    apb(1'b1, IDX_CTRL, 8'h02);
    apb(1'b1, IDX_TRIG, 8'h20);
    repeat (6) @(posedge pclk);
    chk(24'(task_status & 8'h90), 24'h10);
    strobe(0);
    chk(24'(srst), 24'h1);
    apb(1'b1, IDX_TRIG, 8'h40);
    repeat (3) @(posedge pclk);
    chk(24'(srst), 24'h0);
    pio_mode <= 1'b1;
    block_word_count <= 16'h0003;
    apb(1'b1, IDX_CTRL, 8'h08);
    apb(1'b1, IDX_TRIG, 8'h04);
    wait_irq();
    chk({task_count_high, task_count_low, task_reason},
      24'h000802);
    chk(24'(task_status & 8'h88), 24'h08);
    chk({22'h0, cmd_vs_payload_sel, xfer_enable}, 24'h1);
    apb(1'b1, IDX_CTRL, 8'h40);
    strobe(1);
    chk(24'(task_status & 8'h88), 24'h80);
    apb(1'b1, IDX_PEND, 8'h45);
    apb(1'b1, IDX_TRIG, 8'h01);
    wait_irq();
    chk({8'h0, task_status & 8'hcd, task_reason}, 24'h4503);
    apb(1'b1, IDX_TRIG, 8'h02);
    wait_irq();
    chk(24'(task_status & 8'h88), 24'h08);
    pio_mode <= 1'b0;
    direction_out <= 1'b1;
    apb(1'b1, IDX_TRIG, 8'h04);
    repeat (8) @(posedge pclk);
    chk({7'h0, task_status[7], task_reason, 7'h0, cmd_vs_payload_sel},
      24'h010001);
    apb(1'b1, IDX_CNT, 8'h02);
    apb(1'b1, IDX_DBG, 8'h07);
    repeat (2) @(posedge pclk);
    rdc(IDX_CNT, 8'h5f, 8'h03);
    strobe(2);
    chk(24'(micro_irq_n), 24'h0);
    rdc(IDX_FLAGS, 8'h10, 8'h10);
    rdc(IDX_CNT, 8'h1f, 8'h02);
    chk(24'(reloads), 24'h1);
    strobe(3);
    rdc(IDX_DBG, 8'hff, 8'h00);
    apb(1'b1, IDX_CTRL, 8'h81);
    drive_selected <= 1'b1;
    host_cmd_data <= OPC_PACKET;
    strobe(4);
    wait_irq();
    repeat (8) @(posedge pclk);
    chk(24'(task_status & 8'hcd), 24'h48);
    rdc(IDX_FLAGS, 8'h41, 8'h01);
    rdc(IDX_CTRL, 8'h80, 8'h00);
    apb(1'b1, IDX_XFER, 8'h44);
    repeat (6) strobe(6);
    rdc(IDX_FLAGS, 8'h03, 8'h03);
    chk({23'h0, micro_irq_n}, 24'h0);
    rdc(IDX_XFER, 8'h40, 8'h00);
    apb(1'b1, IDX_ACK, 8'h00);
    rdc(IDX_FLAGS, 8'h01, 8'h00);
    rdc(IDX_XFER, 8'h40, 8'h40);
    chk({23'h0, micro_irq_n}, 24'h1);
    apb(1'b1, IDX_TRIG, 8'h08);
    rdc(IDX_FLAGS, 8'h02, 8'h00);
    chk(24'(clears), 24'h2);
    // CRC error holds back auto completion; a clean end then runs it
    apb(1'b1, IDX_CTRL, 8'h74);
    burst_crc_bad <= 1'b1;
    strobe(5);
    repeat (6) @(posedge pclk);
    chk({15'h0, host_irq, task_status & 8'h88}, 24'h80);
    burst_crc_bad <= 1'b0;
    strobe(5);
    wait_irq();
    rdc(IDX_CTRL, 8'ha4, 8'h80);
    apb(1'b1, IDX_DBG, 8'h06);
    strobe(7);
    rdc(IDX_DBG, 8'hff, 8'h00);
    apb(1'b0, 8'hff, 8'h00);
    chk(24'(err), 24'h1);
    end_of_test();
  end
endmodule
